// *** hw/compare_pkg.sv ***
// Types shared by the compare block.
// Assumes the register header is on the include path.
package compare_pkg;

    typedef enum logic [1:0] {
        BUS_IDLE  = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_READ  = 2'b10
    } bus_phase_e;

    typedef struct packed {
        logic [4:0]  control;
        logic [15:0] value;
        logic        latch;
        logic        flag;
    } channel_s;

    typedef struct packed {
        channel_s    ch_a;
        channel_s    ch_b;
        logic [15:0] timer_a;
        logic [15:0] timer_c;
        logic [2:0]  timer_ctrl;
        logic        tovf_a;
        logic        tovf_c;
        bus_phase_e  phase;
        logic [7:0]  addr;
        logic [31:0] rdata;
        logic        adc_start;
        logic        pin_a_oe_n;
        logic        pin_b_oe_n;
        logic        match_a;
        logic        match_b;
        logic [1:0]  dir_m;
        logic [1:0]  dir_s;
    } state_s;

endpackage

// *** hw/compare_regs.svh ***
// Register map, field positions, reset values and mode codes of the compare block.
// Assumes inclusion by the top module, the checker and the bench; holds definitions only.
// Operation
// - Each channel compares its 16-bit value every cycle against timer A or timer C.
// - On match, the 4-bit mode selects drive high, drive low, toggle or unchanged.
// - The channel's interrupt flag sets in the same cycle as the match action.
// - Writing zero to channel control forces the compare output latch low.
// - Software interrupt mode leaves the pin untouched and only raises the interrupt.
// - Special event trigger mode clears whichever timer the channel compares against.
// - Channel A trigger resets the timer it selects (timer A when bit 4 is 0), making its value a programmable period.
// - Channel B trigger also starts a conversion when the converter is enabled.
// - A timer reset from channel B's trigger never sets timer interrupt flags.
`ifndef COMPARE_REGS_SVH
`define COMPARE_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define OFS_CONTROL_A   8'h00
`define OFS_VALUE_A     8'h04
`define OFS_CONTROL_B   8'h08
`define OFS_VALUE_B     8'h0C
`define OFS_STATUS      8'h10
`define OFS_TIMER_A     8'h14
`define OFS_TIMER_C     8'h18
`define OFS_TIMER_CTRL  8'h1C

// ----------------------------------------------------------------------------
// Control fields: [3:0] mode, [4] timer select (1 = timer C)
// ----------------------------------------------------------------------------
`define CTL_MODE_LSB    0
`define CTL_TSEL_BIT    4
`define CTL_RESET       5'h00

// ----------------------------------------------------------------------------
// Status fields: flags write-one-to-clear; timer flags from overflow only
// ----------------------------------------------------------------------------
`define ST_FLAG_A       0
`define ST_FLAG_B       1
`define ST_TOVF_A       2
`define ST_TOVF_C       3
`define ST_PIN_A        4
`define ST_PIN_B        5

// ----------------------------------------------------------------------------
// Timer control fields
// ----------------------------------------------------------------------------
`define TC_RUN_A        0
`define TC_RUN_C        1
`define TC_ADC_EN       2

// ----------------------------------------------------------------------------
// Compare mode codes
// ----------------------------------------------------------------------------
`define MODE_SET_HIGH   4'h8
`define MODE_SET_LOW    4'h9
`define MODE_SOFT_IRQ   4'hA
`define MODE_TRIGGER    4'hB
`define MODE_TOGGLE     4'h2

`endif

// *** hw/compare_unit.sv ***
// Two output-compare channels with timers A and C and an AHB-Lite register slave.
// Assumes a single 40 MHz clock, a synchronous reset and a one-slave AHB-Lite bus.
`timescale 1ns/10ps
`include "compare_regs.svh"

module compare_unit (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [1:0]  portc_direction,
    output logic             compare_pin_a,
    output logic             compare_pin_a_oe_n,
    output logic             compare_pin_b,
    output logic             compare_pin_b_oe_n,
    output logic             compare_irq_flag_a,
    output logic             compare_irq_flag_b,
    output logic             adc_start
);

    compare_pkg::state_s s_reg;
    compare_pkg::state_s s_next;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // New latch level on a match for a given mode
    function automatic logic match_level(input logic [3:0] mode, input logic cur);
        case (mode)
            `MODE_SET_HIGH: match_level = 1'b1;
            `MODE_SET_LOW:  match_level = 1'b0;
            `MODE_TOGGLE:   match_level = ~cur;
            default:        match_level = cur;   // Soft irq and trigger leave pin
        endcase
    endfunction

    // True when the mode is one of the compare modes
    function automatic logic is_compare(input logic [3:0] mode);
        is_compare = (mode == `MODE_SET_HIGH) || (mode == `MODE_SET_LOW) ||
                     (mode == `MODE_TOGGLE) || (mode == `MODE_SOFT_IRQ) ||
                     (mode == `MODE_TRIGGER);
    endfunction

    // Match of one channel against its selected timer
    function automatic logic chan_match(input compare_pkg::channel_s ch,
                                        input logic [15:0] ta,
                                        input logic [15:0] tc);
        logic [15:0] t;
        t = ch.control[`CTL_TSEL_BIT] ? tc : ta;
        chan_match = is_compare(ch.control[3:0]) && (t == ch.value);
    endfunction

    logic        wr_take;
    logic        rd_take;
    logic        trig_a;
    logic        trig_b;
    logic        clr_ta;
    logic        clr_tc;
    logic [31:0] status_word;

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.adc_start = 1'b0;

        // Direction bits pass two flops before use
        s_next.dir_m = portc_direction;
        s_next.dir_s = s_reg.dir_m;
        s_next.pin_a_oe_n = ~s_reg.dir_s[0];
        s_next.pin_b_oe_n = ~s_reg.dir_s[1];

        // Registered compare, every cycle, against timer A or C
        s_next.match_a = chan_match(s_reg.ch_a, s_reg.timer_a, s_reg.timer_c);
        s_next.match_b = chan_match(s_reg.ch_b, s_reg.timer_a, s_reg.timer_c);

        // Matched cycle: pin action and flag together
        trig_a = 1'b0;
        trig_b = 1'b0;
        if (s_reg.match_a) begin
            s_next.ch_a.latch = match_level(s_reg.ch_a.control[3:0], s_reg.ch_a.latch);
            s_next.ch_a.flag = 1'b1;
            trig_a = (s_reg.ch_a.control[3:0] == `MODE_TRIGGER);
        end
        if (s_reg.match_b) begin
            s_next.ch_b.latch = match_level(s_reg.ch_b.control[3:0], s_reg.ch_b.latch);
            s_next.ch_b.flag = 1'b1;
            trig_b = (s_reg.ch_b.control[3:0] == `MODE_TRIGGER);
        end

        // Trigger clears the timer the channel compares against
        clr_ta = (trig_a && !s_reg.ch_a.control[`CTL_TSEL_BIT]) ||
                 (trig_b && !s_reg.ch_b.control[`CTL_TSEL_BIT]);
        clr_tc = (trig_a && s_reg.ch_a.control[`CTL_TSEL_BIT]) ||
                 (trig_b && s_reg.ch_b.control[`CTL_TSEL_BIT]);
        s_next.adc_start = trig_b && s_reg.timer_ctrl[`TC_ADC_EN];

        // Timers: overflow alone sets their flags, never a trigger clear
        if (clr_ta)
            s_next.timer_a = 16'h0000;
        else if (s_reg.timer_ctrl[`TC_RUN_A]) begin
            s_next.timer_a = s_reg.timer_a + 16'h0001;
            if (s_reg.timer_a == 16'hFFFF)
                s_next.tovf_a = 1'b1;
        end
        if (clr_tc)
            s_next.timer_c = 16'h0000;
        else if (s_reg.timer_ctrl[`TC_RUN_C]) begin
            s_next.timer_c = s_reg.timer_c + 16'h0001;
            if (s_reg.timer_c == 16'hFFFF)
                s_next.tovf_c = 1'b1;
        end

        // AHB-Lite address phase capture; zero wait states
        wr_take = hsel && hready && htrans[1] && hwrite;
        rd_take = hsel && hready && htrans[1] && !hwrite;
        s_next.addr = haddr[7:0];
        s_next.phase = wr_take ? compare_pkg::BUS_WRITE :
                       (rd_take ? compare_pkg::BUS_READ : compare_pkg::BUS_IDLE);

        status_word = 32'h0000_0000;
        status_word[`ST_FLAG_A] = s_reg.ch_a.flag;
        status_word[`ST_FLAG_B] = s_reg.ch_b.flag;
        status_word[`ST_TOVF_A] = s_reg.tovf_a;
        status_word[`ST_TOVF_C] = s_reg.tovf_c;
        status_word[`ST_PIN_A]  = s_reg.ch_a.latch;
        status_word[`ST_PIN_B]  = s_reg.ch_b.latch;

        // Read data registered in the address phase so hrdata is a flop
        s_next.rdata = 32'h0000_0000;
        if (rd_take) begin
            case (haddr[7:0])
                `OFS_CONTROL_A:  s_next.rdata = {27'h0, s_reg.ch_a.control};
                `OFS_VALUE_A:    s_next.rdata = {16'h0, s_reg.ch_a.value};
                `OFS_CONTROL_B:  s_next.rdata = {27'h0, s_reg.ch_b.control};
                `OFS_VALUE_B:    s_next.rdata = {16'h0, s_reg.ch_b.value};
                `OFS_STATUS:     s_next.rdata = status_word;
                `OFS_TIMER_A:    s_next.rdata = {16'h0, s_reg.timer_a};
                `OFS_TIMER_C:    s_next.rdata = {16'h0, s_reg.timer_c};
                `OFS_TIMER_CTRL: s_next.rdata = {29'h0, s_reg.timer_ctrl};
                default:         s_next.rdata = 32'h0000_0000;
            endcase
        end

        // Data phase write; software writes lose to same-cycle hardware sets, except a zero control write, which forces the latch low
        if (s_reg.phase == compare_pkg::BUS_WRITE) begin
            case (s_reg.addr)
                `OFS_CONTROL_A: begin
                    s_next.ch_a.control = hwdata[4:0];
                    if (hwdata[4:0] == `CTL_RESET)
                        s_next.ch_a.latch = 1'b0;
                end
                `OFS_CONTROL_B: begin
                    s_next.ch_b.control = hwdata[4:0];
                    if (hwdata[4:0] == `CTL_RESET)
                        s_next.ch_b.latch = 1'b0;
                end
                `OFS_VALUE_A: s_next.ch_a.value = hwdata[15:0];
                `OFS_VALUE_B: s_next.ch_b.value = hwdata[15:0];
                `OFS_STATUS: begin
                    // Write one to clear; a match in this cycle keeps its flag
                    if (hwdata[`ST_FLAG_A] && !s_reg.match_a)
                        s_next.ch_a.flag = 1'b0;
                    if (hwdata[`ST_FLAG_B] && !s_reg.match_b)
                        s_next.ch_b.flag = 1'b0;
                    if (hwdata[`ST_TOVF_A] && !(s_reg.timer_ctrl[`TC_RUN_A] &&
                        s_reg.timer_a == 16'hFFFF && !clr_ta))
                        s_next.tovf_a = 1'b0;
                    if (hwdata[`ST_TOVF_C] && !(s_reg.timer_ctrl[`TC_RUN_C] &&
                        s_reg.timer_c == 16'hFFFF && !clr_tc))
                        s_next.tovf_c = 1'b0;
                end
                // Trigger clear wins over a software timer write
                `OFS_TIMER_A: if (!clr_ta) s_next.timer_a = hwdata[15:0];
                `OFS_TIMER_C: if (!clr_tc) s_next.timer_c = hwdata[15:0];
                `OFS_TIMER_CTRL: s_next.timer_ctrl = hwdata[2:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.phase <= compare_pkg::BUS_IDLE;
            s_reg.pin_a_oe_n <= 1'b1;
            s_reg.pin_b_oe_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from flops, except hreadyout and hresp, which are constants
    assign hrdata             = s_reg.rdata;
    assign hreadyout          = 1'b1;
    assign hresp              = 1'b0;
    assign compare_pin_a      = s_reg.ch_a.latch;
    assign compare_pin_a_oe_n = s_reg.pin_a_oe_n;
    assign compare_pin_b      = s_reg.ch_b.latch;
    assign compare_pin_b_oe_n = s_reg.pin_b_oe_n;
    assign compare_irq_flag_a = s_reg.ch_a.flag;
    assign compare_irq_flag_b = s_reg.ch_b.flag;
    assign adc_start          = s_reg.adc_start;

endmodule

// *** tb/compare_unit_sva.sv ***
// Checker for the compare unit, watching its ports only.
// Assumes the register header on the include path; bound to the top module.
`timescale 1ns/10ps
`include "compare_regs.svh"

module compare_unit_sva (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [1:0]  portc_direction,
    input wire logic        compare_pin_a,
    input wire logic        compare_pin_a_oe_n,
    input wire logic        compare_pin_b_oe_n,
    input wire logic        compare_irq_flag_a,
    input wire logic        compare_irq_flag_b,
    input wire logic        adc_start
);
    // ----------------
    // Write tracking
    // ----------------
    logic wr_st;
    logic wr_ca;
    wire  take = hsel && hready && htrans[1] && hwrite;
    // Address phases remembered; their data arrive one cycle later
    always_ff @(posedge ref_clk) begin
        wr_st <= !rst && take && haddr[7:0] == `OFS_STATUS;
        wr_ca <= !rst && take && haddr[7:0] == `OFS_CONTROL_A;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_keep_a; $fell(compare_irq_flag_a) |-> $past(wr_st) && $past(hwdata[0]); endproperty
    a_keep_a: assert property (p_keep_a) else $error("flag a fell without clear");
    property p_keep_b; $fell(compare_irq_flag_b) |-> $past(wr_st) && $past(hwdata[1]); endproperty
    a_keep_b: assert property (p_keep_b) else $error("flag b fell without clear");
    property p_rise_a; $rose(compare_pin_a) |-> compare_irq_flag_a; endproperty
    a_rise_a: assert property (p_rise_a) else $error("pin a rose without flag");
    property p_fall_a;
        $fell(compare_pin_a) |-> compare_irq_flag_a || $past(wr_ca && hwdata[4:0] == 5'h00);
    endproperty
    a_fall_a: assert property (p_fall_a) else $error("pin a fell without cause");
    property p_zero_a; wr_ca && hwdata[4:0] == 5'h00 |=> !compare_pin_a; endproperty
    a_zero_a: assert property (p_zero_a) else $error("control zero left pin a high");
    property p_adc; adc_start |-> compare_irq_flag_b; endproperty
    a_adc: assert property (p_adc) else $error("conversion start without flag b");
    // Direction sync is three flops deep, so skip windows touched by reset
    property p_oe_a;
        !$past(rst) && !$past(rst, 2) && !$past(rst, 3)
            |-> compare_pin_a_oe_n == !$past(portc_direction[0], 3);
    endproperty
    a_oe_a: assert property (p_oe_a) else $error("pin a enable wrong");
    property p_oe_b;
        !$past(rst) && !$past(rst, 2) && !$past(rst, 3)
            |-> compare_pin_b_oe_n == !$past(portc_direction[1], 3);
    endproperty
    a_oe_b: assert property (p_oe_b) else $error("pin b enable wrong");
endmodule

bind compare_unit compare_unit_sva sva_u (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .portc_direction, .compare_pin_a, .compare_pin_a_oe_n,
    .compare_pin_b_oe_n, .compare_irq_flag_a, .compare_irq_flag_b, .adc_start);

// *** tb/compare_unit_tb.sv ***
// Self-checking bench for the compare unit over AHB-Lite.
// Assumes the register header, pin load model and checker compiled alongside.
`timescale 1ns/10ps
`include "compare_regs.svh"

module compare_unit_tb;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [1:0]  portc_direction = 2'b00;
    logic [31:0] hrdata, q;
    logic        hreadyout, hresp, pin_a, pin_b, oe_a_n, oe_b_n;
    logic        flag_a, flag_b, adc_start, lvl_a, lvl_b;
    int          error_cnt = 0, n_checks = 0, adc_cnt = 0, n0;
    logic [3:0]  md [4] = '{`MODE_SET_HIGH, `MODE_SET_LOW, `MODE_TOGGLE, `MODE_SOFT_IRQ};
    logic        ex [4] = '{1'b1, 1'b0, 1'b1, 1'b1};

    // ----------------
    // Clock, design, load
    // ----------------
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) adc_cnt <= adc_cnt + int'(adc_start === 1'b1);
    compare_unit dut_u (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .portc_direction,
        .compare_pin_a(pin_a), .compare_pin_a_oe_n(oe_a_n), .compare_pin_b(pin_b),
        .compare_pin_b_oe_n(oe_b_n), .compare_irq_flag_a(flag_a),
        .compare_irq_flag_b(flag_b), .adc_start);
    pin_load load_a_u (.pin(pin_a), .pin_oe_n(oe_a_n), .level(lvl_a));
    pin_load load_b_u (.pin(pin_b), .pin_oe_n(oe_b_n), .level(lvl_b));

    // ----------------
    // Tasks
    // ----------------
    // One single transfer; waits on ready instead of assuming latency
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Hang guard, far beyond the roughly 1200 cycles the tests need
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        $display("[FAIL] watchdog expected end seen timeout");
        results();
    end

    // ----------------
    // Tests
    // ----------------
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        bus(1'b0, `OFS_CONTROL_A, 0);
        chk("control_a", q, 0);
        bus(1'b1, 8'h20, 32'hFFFF_FFFF);
        bus(1'b0, 8'h20, 0);
        chk("unmapped", q, 0);
        chk("oe_a_n", 32'(oe_a_n), 1);
        chk("hresp", 32'(hresp), 0);
        portc_direction <= 2'b11;
        $display("test reset done");
        // Timer passes the value once per mode; order makes each mode visible
        bus(1'b1, `OFS_VALUE_A, 32'h0000_1234);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, `OFS_CONTROL_A, 32'(md[i]));
            bus(1'b1, `OFS_TIMER_A, 32'h0000_1200);
            bus(1'b1, `OFS_TIMER_CTRL, 32'h0000_0001);
            repeat (80) @(posedge ref_clk);
            bus(1'b1, `OFS_TIMER_CTRL, 0);
            chk("pin_a", 32'(lvl_a), 32'(ex[i]));
            chk("flag_a", 32'(flag_a), 1);
            bus(1'b1, `OFS_STATUS, 32'h0000_0001);
            @(posedge ref_clk);
            chk("flag_a_clear", 32'(flag_a), 0);
        end
        bus(1'b1, `OFS_CONTROL_A, 0);
        @(posedge ref_clk);
        chk("pin_a_zero", 32'(lvl_a), 0);
        $display("test modes done");
        bus(1'b1, `OFS_VALUE_A, 32'h0000_0064);
        bus(1'b1, `OFS_TIMER_A, 0);
        bus(1'b1, `OFS_CONTROL_A, 32'(`MODE_TRIGGER));
        bus(1'b1, `OFS_TIMER_CTRL, 32'h0000_0001);
        repeat (300) @(posedge ref_clk);
        bus(1'b0, `OFS_TIMER_A, 0);
        chk("timer_a_period", 32'(q <= 32'h0000_0065), 1);
        chk("flag_a_trig", 32'(flag_a), 1);
        $display("test period done");
        // Timer A parked away from channel A's value, so only timer C can match
        bus(1'b1, `OFS_TIMER_CTRL, 0);
        bus(1'b1, `OFS_TIMER_A, 32'h0000_0200);
        bus(1'b1, `OFS_VALUE_B, 32'h0000_0032);
        bus(1'b1, `OFS_TIMER_C, 0);
        bus(1'b1, `OFS_CONTROL_B, 32'h0000_001B);
        bus(1'b1, `OFS_STATUS, 32'h0000_000F);
        n0 = adc_cnt;
        bus(1'b1, `OFS_TIMER_CTRL, 32'h0000_0006);
        repeat (200) @(posedge ref_clk);
        bus(1'b1, `OFS_TIMER_CTRL, 32'h0000_0002);
        chk("adc_pulses", 32'(adc_cnt - n0 > 2), 1);
        bus(1'b0, `OFS_STATUS, 0);
        chk("timer_flags", 32'(q[3:2]), 0);
        bus(1'b1, `OFS_STATUS, 32'h0000_0002);
        n0 = adc_cnt;
        repeat (200) @(posedge ref_clk);
        chk("adc_off", 32'(adc_cnt - n0), 0);
        chk("flag_b", 32'(flag_b), 1);
        bus(1'b0, `OFS_TIMER_C, 0);
        chk("timer_c_period", 32'(q <= 32'h0000_0033), 1);
        chk("pin_b_trig", 32'(lvl_b), 0);
        $display("test trigger done");
        // Channel B drives high against timer A; timer C stops so only A can match
        bus(1'b1, `OFS_CONTROL_B, 32'h0000_0008);
        bus(1'b1, `OFS_VALUE_B, 32'h0000_0210);
        bus(1'b1, `OFS_TIMER_A, 32'h0000_0200);
        bus(1'b1, `OFS_TIMER_CTRL, 32'h0000_0001);
        repeat (40) @(posedge ref_clk);
        chk("pin_b_high", 32'(lvl_b), 1);
        $display("test pin b done");
        results();
    end
endmodule

// *** tb/pin_load.sv ***
// External load on one compare pin, with a weak pull-down.
// Assumes an active-low output enable from the compare unit.
`timescale 1ns/10ps

module pin_load (
    input  wire logic pin,
    input  wire logic pin_oe_n,
    output logic      level
);
    // ----------------
    // Pin level
    // ----------------
    // Released pin drifts to the pull-down, never the last driven value
    assign level = pin_oe_n ? 1'b0 : pin;
endmodule
